// ---- hdl/svwd_top.sv ----
// Control logic of a voltage supervisor with window watchdog.
// Assumes comparator results and pins are synchronous to clk.
// Assumes one clock of the period in svwd_defs.svh; every delay is a cycle count.
// Assumes the host changes one select pin at a time and holds kicks idle high.
`timescale 1ns/1ps
`include "svwd_defs.svh"

module svwd_top #(
  parameter bit                    ADJUSTABLE   = 1'b0,
  parameter logic [`SVWD_CNT_W-1:0] RST_OPEN_CYC = `SVWD_CNT_W'(`SVWD_RST_OPEN_MS * `SVWD_MS_CYC),
  parameter logic [`SVWD_CNT_W-1:0] RST_PULL_CYC = `SVWD_CNT_W'(`SVWD_RST_PULL_MS * `SVWD_MS_CYC),
  parameter logic [`SVWD_CNT_W-1:0] WDU_OPEN_CYC = `SVWD_CNT_W'(`SVWD_WDU_OPEN_MS * `SVWD_MS_CYC),
  parameter logic [`SVWD_CNT_W-1:0] WDU_PULL_CYC = `SVWD_CNT_W'(`SVWD_WDU_PULL_MS * `SVWD_MS_CYC)
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire svwd_pkg::svwd_sense_t  sense,
  input  wire svwd_pkg::svwd_cfgpin_t reset_delay_config_pin,
  input  wire logic [`SVWD_CNT_W-1:0] cap_delay_cyc,
  input  wire logic [`SVWD_CNT_W-1:0] cap_window_cyc,
  input  wire logic                   watchdog_timing_cap,
  input  wire logic                   ratio_select_a,
  input  wire logic                   ratio_select_b,
  input  wire logic                   watchdog_kick_input,
  output logic                        reset_out_o,
  output logic                        reset_out_oe,
  output logic                        watchdog_fault_output_o,
  output logic                        watchdog_fault_output_oe,
  output svwd_pkg::svwd_opt_t         delay_option,
  output logic                        watchdog_enabled
);
  import svwd_pkg::*;

  // Settle and capacitor limits in clock cycles
  localparam logic [`SVWD_CNT_W-1:0] SETTLE_CYC  = `SVWD_CNT_W'(`SVWD_SETTLE_CYC);
  localparam logic [`SVWD_CNT_W-1:0] CAP_MIN_CYC = `SVWD_CNT_W'(`SVWD_RST_CAP_MIN_US * `SVWD_US_CYC);
  localparam logic [`SVWD_CNT_W-1:0] CAP_MAX_CYC = `SVWD_CNT_W'(`SVWD_RST_CAP_MAX_MS * `SVWD_MS_CYC);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (RST_OPEN_CYC == '0 || RST_PULL_CYC == '0) begin : g_bad_delay
    $error("svwd_top: reset delay counts must be nonzero");
  end
  if (WDU_OPEN_CYC < 32'd8 || WDU_PULL_CYC < 32'd8) begin : g_bad_window
    $error("svwd_top: upper window counts must be at least 8 cycles");
  end
  if (`SVWD_CNT_W < 32) begin : g_bad_width
    $error("svwd_top: counter width too small for the longest delay");
  end
  if (CAP_MIN_CYC >= CAP_MAX_CYC) begin : g_bad_cap
    $error("svwd_top: capacitor delay range is empty");
  end

  // Select pins to mode, used for both live and latched codes
  function automatic svwd_mode_t sel_mode(input logic a, input logic b);
    if (a && !b) begin
      sel_mode = SVWD_RATIO_DIS;
    end else if (!a && !b) begin
      sel_mode = SVWD_RATIO_1_8;
    end else if (!a && b) begin
      sel_mode = SVWD_RATIO_3_4;
    end else begin
      sel_mode = SVWD_RATIO_1_2;
    end
  endfunction : sel_mode

  // Lower bound from upper bound and ratio
  function automatic logic [`SVWD_CNT_W-1:0] lower_of(input logic [`SVWD_CNT_W-1:0] up,
                                                       input svwd_mode_t m);
    case (m)
      SVWD_RATIO_1_8: lower_of = up >> 3;
      SVWD_RATIO_3_4: lower_of = (up >> 1) + (up >> 2);
      default:        lower_of = up >> 1;
    endcase
  endfunction : lower_of

  // Capacitor delay held to its programmable range
  function automatic logic [`SVWD_CNT_W-1:0] clamp_cap(input logic [`SVWD_CNT_W-1:0] d);
    if (d < CAP_MIN_CYC) begin
      clamp_cap = CAP_MIN_CYC;
    end else if (d > CAP_MAX_CYC) begin
      clamp_cap = CAP_MAX_CYC;
    end else begin
      clamp_cap = d;
    end
  endfunction : clamp_cap

  typedef struct packed {
    logic                   in_window;
    logic                   rst_active;
    logic [`SVWD_CNT_W-1:0] rst_cnt;
    logic                   cl_wait;
    svwd_mode_t             ratio_lat;
    svwd_wd_state_t         wd_st;
    logic [`SVWD_CNT_W-1:0] wd_cnt;
    logic                   first_kick;
    logic                   kick_d;
    logic                   was_enabled;
    logic                   flt_at_off;
  } svwd_st_t;

  svwd_st_t state_reg;
  svwd_st_t state_next;

  logic       cl_start;
  logic       cl_busy;
  svwd_opt_t  cl_opt;
  svwd_mode_t live_mode;
  logic       window_ok;
  logic       kick_fall;
  logic [`SVWD_CNT_W-1:0] delay_cyc;
  logic [`SVWD_CNT_W-1:0] upper_cyc;
  logic [`SVWD_CNT_W-1:0] lower_cyc;
  logic [`SVWD_CNT_W-1:0] cap_clamped;

  // ****************************************
  // Configuration pin classification
  // ****************************************
  svwd_classifier u_classifier (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (cl_start),
    .obs    (reset_delay_config_pin),
    .busy   (cl_busy),
    .option (cl_opt)
  );

  // ****************************************
  // Derived timing and window decisions
  // ****************************************
  always_comb begin
    // Adjustable variant has no overvoltage check
    window_ok = sense.supply_ok && !sense.below_uv && (ADJUSTABLE || !sense.above_ov);
    // Entry edge only; a rail that stays valid is not re-evaluated
    cl_start  = window_ok && !state_reg.in_window;
    live_mode = sel_mode(ratio_select_a, ratio_select_b);
    // Kick detector idles high, so reset leaves no false edge
    kick_fall = state_reg.kick_d && !watchdog_kick_input;
    cap_clamped = clamp_cap(cap_delay_cyc);
    // Delay follows the classified option
    case (cl_opt)
      SVWD_OPT_CAP:    delay_cyc = cap_clamped;
      SVWD_OPT_PULLUP: delay_cyc = RST_PULL_CYC;
      default:         delay_cyc = RST_OPEN_CYC;
    endcase
    if (watchdog_timing_cap) begin
      upper_cyc = cap_window_cyc;
    end else if (reset_delay_config_pin.pin_high) begin
      upper_cyc = WDU_PULL_CYC;
    end else begin
      upper_cyc = WDU_OPEN_CYC;
    end
    // Lower bound follows the ratio latched at the last reset event
    lower_cyc = lower_of(upper_cyc, state_reg.ratio_lat);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next        = state_reg;
    state_next.kick_d = watchdog_kick_input;
    state_next.in_window = window_ok;

    // Reset output supervision
    if (!window_ok) begin
      state_next.rst_active = 1'b1;
      state_next.cl_wait    = 1'b0;
      state_next.rst_cnt    = '0;
      // Ratio only re-latched while the rail is out
      state_next.ratio_lat  = live_mode;
    end else if (cl_start) begin
      state_next.cl_wait = 1'b1;
      state_next.rst_cnt = '0;
    end else if (state_reg.rst_active) begin
      if (state_reg.cl_wait) begin
        state_next.cl_wait = cl_busy;
      end else if (state_reg.rst_cnt >= delay_cyc - 1'b1) begin
        state_next.rst_active = 1'b0;
      end else begin
        state_next.rst_cnt = state_reg.rst_cnt + 1'b1;
      end
    end

    // Window watchdog
    state_next.was_enabled = (live_mode != SVWD_RATIO_DIS);
    if (state_reg.rst_active) begin
      state_next.wd_st      = SVWD_WD_OFF;
      state_next.wd_cnt     = '0;
      state_next.first_kick = 1'b1;
      state_next.flt_at_off = 1'b0;
    end else if (live_mode == SVWD_RATIO_DIS) begin
      state_next.wd_st = SVWD_WD_OFF;
      state_next.wd_cnt = '0;
      state_next.first_kick = 1'b1;
      // Remember a fault cut short by the disable
      state_next.flt_at_off = state_reg.flt_at_off || (state_reg.wd_st == SVWD_WD_FAULT);
    end else begin
      case (state_reg.wd_st)
        SVWD_WD_OFF: begin
          state_next.wd_cnt     = '0;
          state_next.first_kick = 1'b1;
          state_next.flt_at_off = 1'b0;
          if (!state_reg.was_enabled || state_reg.in_window) begin
            state_next.wd_st = SVWD_WD_SETTLE;
          end
        end
        SVWD_WD_SETTLE: begin
          // Kicks ignored while settling
          // Count may start below zero to add a full delay first
          state_next.wd_cnt = state_reg.wd_cnt + 1'b1;
          if (state_reg.wd_cnt == SETTLE_CYC - 1'b1) begin
            state_next.wd_st  = SVWD_WD_RUN;
            state_next.wd_cnt = '0;
          end
        end
        SVWD_WD_RUN: begin
          // First kick after enable or fault only needs the upper bound
          state_next.wd_cnt = state_reg.wd_cnt + 1'b1;
          if (kick_fall) begin
            state_next.wd_cnt     = '0;
            state_next.first_kick = 1'b0;
            if (!state_reg.first_kick && state_reg.wd_cnt < lower_cyc) begin
              state_next.wd_st = SVWD_WD_FAULT;
            end
          end else if (state_reg.wd_cnt >= upper_cyc - 1'b1) begin
            state_next.wd_st  = SVWD_WD_FAULT;
            state_next.wd_cnt = '0;
          end
          if (state_next.wd_st == SVWD_WD_FAULT) begin
            state_next.wd_cnt = '0;
          end
        end
        default: begin
          // Fault held one delay period
          state_next.wd_cnt = state_reg.wd_cnt + 1'b1;
          if (state_reg.wd_cnt >= delay_cyc - 1'b1) begin
            state_next.wd_st      = SVWD_WD_RUN;
            state_next.wd_cnt     = '0;
            state_next.first_kick = 1'b1;
          end
        end
      endcase
    end

    // Fixed delay re-enables as usual; capacitor delay, after a fault cut short by the disable, first waits a full delay
    if (!state_reg.rst_active && live_mode != SVWD_RATIO_DIS && !state_reg.was_enabled
        && state_reg.wd_st == SVWD_WD_OFF && state_reg.flt_at_off && cl_opt == SVWD_OPT_CAP) begin
      state_next.wd_st      = SVWD_WD_SETTLE;
      state_next.wd_cnt     = '0 - delay_cyc;
      state_next.flt_at_off = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '{in_window: 1'b0, rst_active: 1'b1, rst_cnt: '0, cl_wait: 1'b0,
                     ratio_lat: SVWD_RATIO_1_8, wd_st: SVWD_WD_OFF, wd_cnt: '0,
                     first_kick: 1'b1, kick_d: 1'b1, was_enabled: 1'b0, flt_at_off: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Open-drain outputs
  // ****************************************
  assign reset_out_o              = 1'b0;
  assign reset_out_oe             = state_reg.rst_active;
  assign watchdog_fault_output_o  = 1'b0;
  // Fault is released whenever reset is asserted
  assign watchdog_fault_output_oe = (state_reg.wd_st == SVWD_WD_FAULT) && !state_reg.rst_active;
  assign delay_option             = cl_opt;
  assign watchdog_enabled         = (state_reg.wd_st == SVWD_WD_RUN);

endmodule : svwd_top

// ---- hdl/svwd_defs.svh ----
// Timing constants for the supervisor / window watchdog control block.
// Assumes a 200 MHz core clock; counts derive from times in us and ms.
`ifndef SVWD_DEFS_SVH
`define SVWD_DEFS_SVH

`define SVWD_CLK_PERIOD_NS     5
`define SVWD_CLASSIFY_US       381
`define SVWD_CLASSIFY_CYC      ((`SVWD_CLASSIFY_US * 1000) / `SVWD_CLK_PERIOD_NS)
`define SVWD_SETTLE_US         150
`define SVWD_SETTLE_CYC        ((`SVWD_SETTLE_US * 1000) / `SVWD_CLK_PERIOD_NS)
`define SVWD_RST_OPEN_MS       200
`define SVWD_RST_PULL_MS       10
`define SVWD_RST_CAP_MIN_US    703
`define SVWD_RST_CAP_MAX_MS    3220
`define SVWD_MS_CYC            64'd200000
`define SVWD_US_CYC            64'd200
`define SVWD_WDU_OPEN_MS       55
`define SVWD_WDU_PULL_MS       109
`define SVWD_CNT_W             32

`endif

// ---- hdl/svwd_pkg.sv ----
// Types shared by the supervisor / window watchdog control block.
// Assumes svwd_defs.svh for numeric constants.
package svwd_pkg;

  typedef enum logic [1:0] {
    SVWD_OPT_OPEN,
    SVWD_OPT_PULLUP,
    SVWD_OPT_CAP
  } svwd_opt_t;

  typedef enum logic [1:0] {
    SVWD_RATIO_1_8,
    SVWD_RATIO_DIS,
    SVWD_RATIO_3_4,
    SVWD_RATIO_1_2
  } svwd_mode_t;

  typedef enum logic [1:0] {
    SVWD_CL_IDLE,
    SVWD_CL_MEASURE,
    SVWD_CL_DONE
  } svwd_cl_state_t;

  typedef enum logic [1:0] {
    SVWD_WD_OFF,
    SVWD_WD_SETTLE,
    SVWD_WD_RUN,
    SVWD_WD_FAULT
  } svwd_wd_state_t;

  // Analog comparator results and supply status
  typedef struct packed {
    logic supply_ok;
    logic below_uv;
    logic above_ov;
  } svwd_sense_t;

  // Raw pin observations of the reset delay configuration pin
  typedef struct packed {
    logic pin_high;
    logic pin_cap;
  } svwd_cfgpin_t;

endpackage : svwd_pkg

// ---- hdl/svwd_classifier.sv ----
// Classifier for the reset-delay configuration pin.
// Assumes pin observation inputs synchronous to clk.
`timescale 1ns/1ps
`include "svwd_defs.svh"

module svwd_classifier (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   start,
  input  wire svwd_pkg::svwd_cfgpin_t obs,
  output logic                        busy,
  output svwd_pkg::svwd_opt_t         option
);
  import svwd_pkg::*;

  localparam logic [`SVWD_CNT_W-1:0] CL_CYC = `SVWD_CNT_W'(`SVWD_CLASSIFY_CYC);

  typedef struct packed {
    svwd_cl_state_t         st;
    logic [`SVWD_CNT_W-1:0] cnt;
    svwd_opt_t              opt;
  } svwd_cl_t;

  svwd_cl_t state_reg;
  svwd_cl_t state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg.st)
      SVWD_CL_IDLE: begin
        if (start) begin
          state_next.st  = SVWD_CL_MEASURE;
          state_next.cnt = '0;
        end
      end
      SVWD_CL_MEASURE: begin
        // Fixed-length evaluation, decided at its end
        state_next.cnt = state_reg.cnt + 1'b1;
        if (start) begin
          // Re-entry restarts the evaluation
          state_next.cnt = '0;
        end else if (state_reg.cnt == CL_CYC - 1'b1) begin
          state_next.st = SVWD_CL_DONE;
          if (obs.pin_cap) begin
            state_next.opt = SVWD_OPT_CAP;
          end else if (obs.pin_high) begin
            state_next.opt = SVWD_OPT_PULLUP;
          end else begin
            state_next.opt = SVWD_OPT_OPEN;
          end
        end
      end
      default: begin
        if (start) begin
          state_next.st  = SVWD_CL_MEASURE;
          state_next.cnt = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '{st: SVWD_CL_IDLE, cnt: '0, opt: SVWD_OPT_OPEN};
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy   = (state_reg.st != SVWD_CL_DONE);
  assign option = state_reg.opt;

endmodule : svwd_classifier

// ---- sim/svwd_top_monitor.sv ----
// Concurrent checks on the supervisor / window watchdog ports.
// Assumes binding onto svwd_top, svwd_defs.svh on the include path.
`timescale 1ns/1ps
`include "svwd_defs.svh"

module svwd_mon import svwd_pkg::*; #(
  parameter bit                     ADJUSTABLE   = 1'b0,
  parameter logic [`SVWD_CNT_W-1:0] RST_OPEN_CYC = 32'h0000_00c8,
  parameter logic [`SVWD_CNT_W-1:0] RST_PULL_CYC = 32'h0000_0064
) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire svwd_pkg::svwd_sense_t  sense,
  input wire logic [`SVWD_CNT_W-1:0] cap_delay_cyc,
  input wire logic                   ratio_select_a,
  input wire logic                   ratio_select_b,
  input wire logic                   reset_out_o,
  input wire logic                   reset_out_oe,
  input wire logic                   watchdog_fault_output_o,
  input wire logic                   watchdog_fault_output_oe,
  input wire svwd_pkg::svwd_opt_t    delay_option,
  input wire logic                   watchdog_enabled
);
  // ********************
  // Helper counters
  // ********************
  localparam int CLASSIFY_CYC = `SVWD_CLASSIFY_CYC;
  logic        win_ok;
  logic [31:0] ok_cnt_reg;
  logic [31:0] flt_len_reg;
  logic [31:0] hold_exp;
  logic [31:0] cap_exp;
  localparam logic [31:0] CAP_LO = 32'(`SVWD_RST_CAP_MIN_US * `SVWD_US_CYC);
  localparam logic [31:0] CAP_HI = 32'(`SVWD_RST_CAP_MAX_MS * `SVWD_MS_CYC);
  assign win_ok   = sense.supply_ok & ~sense.below_uv & (ADJUSTABLE | ~sense.above_ov);
  assign cap_exp  = (cap_delay_cyc < CAP_LO) ? CAP_LO : (cap_delay_cyc > CAP_HI) ? CAP_HI : cap_delay_cyc;
  assign hold_exp = (delay_option == SVWD_OPT_OPEN)   ? RST_OPEN_CYC :
                    (delay_option == SVWD_OPT_PULLUP) ? RST_PULL_CYC : cap_exp;
  always_ff @(posedge clk) begin
    if (!rst_n || !win_ok) begin
      ok_cnt_reg <= 32'h0;
    end else if (ok_cnt_reg != 32'hffff_ffff) begin
      ok_cnt_reg <= ok_cnt_reg + 32'h1;
    end
    flt_len_reg <= (rst_n && watchdog_fault_output_oe) ? flt_len_reg + 32'h1 : 32'h0;
  end
  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wd_off;
    ratio_select_a && !ratio_select_b;
  endsequence
  sequence s_flt_end;
    $fell(watchdog_fault_output_oe) && !reset_out_oe && win_ok && !(ratio_select_a && !ratio_select_b);
  endsequence
  a_rail_loss_reset: assert property (!win_ok |=> reset_out_oe)
    else $error("reset not asserted after rail left window");
  a_open_drain_low: assert property (reset_out_o == 1'b0 && watchdog_fault_output_o == 1'b0)
    else $error("open-drain output drives high");
  a_delay_after_entry: assert property (!reset_out_oe |-> ok_cnt_reg >= CLASSIFY_CYC + hold_exp)
    else $error("reset released before classification and delay");
  a_fault_off_reset: assert property (reset_out_oe && $past(reset_out_oe) |-> !watchdog_fault_output_oe)
    else $error("fault asserted while reset asserted");
  a_wd_off_quiet: assert property (s_wd_off ##1 s_wd_off |-> !watchdog_fault_output_oe)
    else $error("fault asserted while watchdog disabled");
  a_disable_at_once: assert property (s_wd_off ##1 s_wd_off |-> !watchdog_enabled)
    else $error("watchdog still running after disable");
  a_run_needs_release: assert property (reset_out_oe && $past(reset_out_oe) |-> !watchdog_enabled)
    else $error("watchdog running during reset");
  a_fault_hold_len: assert property (s_flt_end |-> flt_len_reg + 32'h2 >= hold_exp)
    else $error("fault released before one delay period");
  a_fault_from_run: assert property ($rose(watchdog_fault_output_oe) |-> $past(watchdog_enabled))
    else $error("fault raised while watchdog not running");
endmodule : svwd_mon

bind svwd_top svwd_mon #(.ADJUSTABLE(ADJUSTABLE), .RST_OPEN_CYC(RST_OPEN_CYC), .RST_PULL_CYC(RST_PULL_CYC)) u_mon (
  .clk(clk), .rst_n(rst_n), .sense(sense), .cap_delay_cyc(cap_delay_cyc),
  .ratio_select_a(ratio_select_a), .ratio_select_b(ratio_select_b),
  .reset_out_o(reset_out_o), .reset_out_oe(reset_out_oe),
  .watchdog_fault_output_o(watchdog_fault_output_o), .watchdog_fault_output_oe(watchdog_fault_output_oe),
  .delay_option(delay_option), .watchdog_enabled(watchdog_enabled));

// ---- sim/svwd_host.sv ----
// Host processor model: issues kicks, sees reset and fault pins.
// Assumes pull-ups on both open-drain pins.
`timescale 1ns/1ps

module svwd_host (
  input  wire logic clk,
  input  wire logic kick_req,
  input  wire logic reset_out_o,
  input  wire logic reset_out_oe,
  input  wire logic watchdog_fault_output_o,
  input  wire logic watchdog_fault_output_oe,
  output logic      watchdog_kick_input,
  output logic      reset_pin_n,
  output logic      fault_pin_n
);
  // ********************
  // Pins and kick pulse
  // ********************
  logic req_seen;
  int   low_cnt;
  assign reset_pin_n = reset_out_oe ? reset_out_o : 1'b1;
  assign fault_pin_n = watchdog_fault_output_oe ? watchdog_fault_output_o : 1'b1;
  initial begin
    watchdog_kick_input = 1'b1;
    req_seen = 1'b0;
    low_cnt = 0;
  end
  always @(posedge clk) begin
    req_seen <= kick_req;
  end
  // Falling edge per request, held low 12 cycles
  always @(negedge clk) begin
    if (req_seen) begin
      watchdog_kick_input <= 1'b0;
      low_cnt <= 12;
    end else if (low_cnt > 1) begin
      low_cnt <= low_cnt - 1;
    end else begin
      low_cnt <= 0;
      watchdog_kick_input <= 1'b1;
    end
  end
endmodule : svwd_host

// ---- sim/svwd_top_tb.sv ----
// Self-checking bench for the supervisor / window watchdog block.
// Assumes small delay parameters; open config pin, ratio 1:8.
`timescale 1ns/1ps

module svwd_top_tb;
  import svwd_pkg::*;
  // ********************
  // Nets and instances
  // ********************
  logic         clk, rst_n, sel_a, sel_b, tcap, kick_req, kick, rst_pin_n, flt_pin_n;
  logic         oe_rst, oe_flt, drv_rst, drv_flt, wd_en;
  logic [31:0]  cap_dly, cap_win;
  svwd_sense_t  sense;
  svwd_cfgpin_t cfg;
  svwd_opt_t    opt;
  int           miscompares, checks_done, n;
  svwd_top #(.RST_OPEN_CYC(32'h0000_00c8), .RST_PULL_CYC(32'h0000_0064), .WDU_OPEN_CYC(32'h0000_0190),
    .WDU_PULL_CYC(32'h0000_0190)) uut (.clk(clk), .rst_n(rst_n), .sense(sense), .reset_delay_config_pin(cfg),
    .cap_delay_cyc(cap_dly), .cap_window_cyc(cap_win), .watchdog_timing_cap(tcap), .ratio_select_a(sel_a),
    .ratio_select_b(sel_b), .watchdog_kick_input(kick), .reset_out_o(drv_rst), .reset_out_oe(oe_rst),
    .watchdog_fault_output_o(drv_flt), .watchdog_fault_output_oe(oe_flt), .delay_option(opt),
    .watchdog_enabled(wd_en));
  svwd_host host (.clk(clk), .kick_req(kick_req), .reset_out_o(drv_rst), .reset_out_oe(oe_rst),
    .watchdog_fault_output_o(drv_flt), .watchdog_fault_output_oe(oe_flt), .watchdog_kick_input(kick),
    .reset_pin_n(rst_pin_n), .fault_pin_n(flt_pin_n));
  always #2.5 clk = ~clk;
  // ********************
  // Tasks
  // ********************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  function automatic logic pick(input int s);
    return (s == 0) ? oe_rst : (s == 1) ? oe_flt : wd_en;
  endfunction : pick
  task automatic wait_lvl(input int s, input logic lvl, input int lim, output int k);
    k = 0;
    while (pick(s) !== lvl && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_lvl
  // Kick falling edges spaced k cycles from the previous request
  task automatic kick_after(input int k);
    cyc(k - 1);
    kick_req = 1'b1;
    cyc(1);
    kick_req = 1'b0;
  endtask : kick_after
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // ********************
  // Tests
  // ********************
  initial begin
    #800000;
    miscompares++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    clk = 1'b0; rst_n = 1'b0; sel_a = 1'b0; sel_b = 1'b0; tcap = 1'b0; kick_req = 1'b0;
    cap_dly = 32'h0000_0400; cap_win = 32'h0000_0400; cfg = '0;
    sense = '{supply_ok: 1'b1, below_uv: 1'b1, above_ov: 1'b0};
    miscompares = 0; checks_done = 0;
    cyc(10);
    rst_n = 1'b1;
    cyc(5);
    check(oe_rst, 1'b1, "reset with rail low");
    sense.below_uv = 1'b0;
    sense.above_ov = 1'b1;
    cyc(3);
    check(oe_rst, 1'b1, "reset with rail high");
    sense.above_ov = 1'b0;
    cyc(76000);
    check(oe_rst, 1'b1, "reset during classify");
    wait_lvl(0, 1'b0, 1000, n);
    check(n >= 395 && n <= 410, 1'b1, "release time");
    check(opt, SVWD_OPT_OPEN, "classified option");
    check(rst_pin_n, 1'b1, "reset pin released");
    $display("test reset release done");
    wait_lvl(2, 1'b1, 31000, n);
    check(n >= 29990 && n <= 30010, 1'b1, "enable settle");
    kick_after(300);
    cyc(4);
    check(oe_flt, 1'b0, "first kick late in window");
    kick_after(100);
    cyc(4);
    check(oe_flt, 1'b0, "kick inside window");
    kick_after(45);
    wait_lvl(1, 1'b1, 10, n);
    check(flt_pin_n, 1'b0, "early kick fault");
    wait_lvl(1, 1'b0, 300, n);
    check(n >= 195 && n <= 205, 1'b1, "fault hold");
    wait_lvl(1, 1'b1, 500, n);
    check(n >= 390 && n <= 410, 1'b1, "missed kick timeout");
    $display("test window kicks done");
    sel_a = 1'b1;
    cyc(3);
    check(oe_flt, 1'b0, "disable drops fault");
    check(wd_en, 1'b0, "disable at once");
    cyc(600);
    check(oe_flt, 1'b0, "disabled stays quiet");
    sel_a = 1'b0;
    $display("test disable done");
    sense.below_uv = 1'b1;
    cyc(2);
    check(oe_rst, 1'b1, "undervoltage reset");
    check(wd_en, 1'b0, "watchdog off in reset");
    kick_after(10);
    cyc(500);
    check(oe_flt, 1'b0, "kicks ignored in reset");
    $display("test rail loss done");
    give_verdict();
  end
endmodule : svwd_top_tb
